// ### hw/prds_pkg.sv
package prds_pkg;
	// ****************************************
	// state encoding
	// ****************************************
	typedef enum logic [2:0]
	{
		PRDS_IDLE = 3'h0,
		PRDS_PARK = 3'h1,
		PRDS_DRAIN = 3'h3,
		PRDS_CLEAR = 3'h2,
		PRDS_RESET = 3'h6,
		PRDS_RECFG = 3'h7
	} prds_state_t;

	// ****************************************
	// widths, reset values and timing
	// ****************************************
	localparam int BASE_EN_W = 6;
	localparam logic [BASE_EN_W-1:0] BASE_EN_RST = 6'h00;
	localparam logic BME_RST = 1'b0;
	localparam logic MSE_RST = 1'b0;
	localparam int SYNC_W = 2;
	localparam int SYNC_PRST = 0;
	localparam int SYNC_PARK = 1;
	// pin idle levels: reset pin released high, bus not parked
	localparam logic [SYNC_W-1:0] SYNC_RST = 2'h1;
	localparam int CLK_PERIOD_PS = 8000;
	localparam int RESET_HOLD_NS = 80;
	localparam int RESET_HOLD_CYC =
		(RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(RESET_HOLD_CYC);
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
endpackage

// ### hw/prds_sequencer.sv
`timescale 1ns/1ps
module prds_sequencer
(
	input wire logic CLOCK_I,
	input wire logic RESET_I,
	input wire logic PCI_RST_N_I,
	input wire logic BUS_PARKED_I,
	input wire logic DISCONNECT_REQ_I,
	input wire logic DMA_BUSY_I,
	input wire logic MASTER_BUSY_I,
	input wire logic LOCAL_WR_I,
	input wire logic HOST_WR_I,
	input wire logic [prds_pkg::BASE_EN_W-1:0] WR_BASE_EN_I,
	input wire logic WR_BUS_MASTER_ENABLE_I,
	input wire logic WR_MEMORY_SPACE_ENABLE_I,
	input wire logic RECONFIG_DONE_I,
	input wire logic MAX_RESET_REQ_I,
	input wire logic STATE_CTRL_DISABLE_I,
	output logic PCI_INT_RST_O,
	output logic DEVICE_RST_O,
	output logic PCI_OE_N_O,
	output logic STOP_XFER_O,
	output logic [prds_pkg::BASE_EN_W-1:0] SLAVE_BASE_EN_O,
	output logic BUS_MASTER_ENABLE_O,
	output logic MEMORY_SPACE_ENABLE_O,
	output logic ACCESS_RESPOND_O,
	output logic XFER_ALLOW_O,
	output logic SEQ_BUSY_O,
	output logic STATE_CTRL_REFUSED_O,
	output logic MAX_RESET_CONFLICT_O
);
	prds_pkg::prds_state_t state;
	prds_pkg::prds_state_t next_state;
	logic [prds_pkg::CNT_W-1:0] joint_cnt;
	logic [prds_pkg::CNT_W-1:0] int_cnt;
	logic [prds_pkg::BASE_EN_W-1:0] slave_control_reg;
	logic bus_master_enable;
	logic memory_space_enable;
	logic configured;
	logic pin_rst;
	logic parked;
	logic enables_clear;
	logic wr_any;
	logic wr_open;
	logic max_hit;
	logic sc_accept;
	logic in_reset;
	logic next_mse;

	// ****************************************
	// pin capture
	// ****************************************
	prds_sync_if sync_bus ();
	// one driver for the whole vector; bit order follows SYNC_PARK and SYNC_PRST
	assign sync_bus.raw = {BUS_PARKED_I, PCI_RST_N_I};

	prds_sync u_sync
	(
		.clock_i(CLOCK_I),
		.reset_i(RESET_I),
		.port(sync_bus.sync)
	);

	assign pin_rst = ~sync_bus.clean[prds_pkg::SYNC_PRST];
	assign parked = sync_bus.clean[prds_pkg::SYNC_PARK];
	assign enables_clear = (slave_control_reg == prds_pkg::BASE_EN_RST) && !bus_master_enable
		&& !memory_space_enable;
	assign wr_any = LOCAL_WR_I || HOST_WR_I;
	// writes are frozen from the park step until reset has been released
	assign wr_open = (state == prds_pkg::PRDS_IDLE) || (state == prds_pkg::PRDS_RECFG);
	assign max_hit = MAX_RESET_REQ_I && (int_cnt == prds_pkg::CNT_ZERO);
	// once configured a state-control disable would split the two resets, so refuse it
	assign sc_accept = STATE_CTRL_DISABLE_I && !configured && (int_cnt == prds_pkg::CNT_ZERO);
	assign in_reset = RESET_I || (state == prds_pkg::PRDS_RESET) || (int_cnt != prds_pkg::CNT_ZERO);

	// ****************************************
	// disconnect sequence
	// ****************************************
	always_comb
	begin
		next_state = state;
		case (state)
			prds_pkg::PRDS_IDLE:
				if (pin_rst)
					next_state = prds_pkg::PRDS_RESET;
				else if (DISCONNECT_REQ_I)
					next_state = prds_pkg::PRDS_PARK;
			prds_pkg::PRDS_PARK:
				if (!parked)
					next_state = prds_pkg::PRDS_DRAIN;
			prds_pkg::PRDS_DRAIN:
				if (!DMA_BUSY_I && !MASTER_BUSY_I)
					next_state = prds_pkg::PRDS_CLEAR;
			prds_pkg::PRDS_CLEAR:
				if (enables_clear)
					next_state = prds_pkg::PRDS_RESET;
			prds_pkg::PRDS_RESET:
				if (joint_cnt == prds_pkg::CNT_ONE && !pin_rst)
					next_state = prds_pkg::PRDS_RECFG;
			prds_pkg::PRDS_RECFG:
				if (pin_rst)
					next_state = prds_pkg::PRDS_RESET;
				else if (RECONFIG_DONE_I)
					next_state = prds_pkg::PRDS_IDLE;
			default:
				next_state = prds_pkg::PRDS_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (RESET_I)
			state <= prds_pkg::PRDS_RECFG;
		else if (pin_rst && state != prds_pkg::PRDS_RESET)
			state <= prds_pkg::PRDS_RESET;
		else
			state <= next_state;
	end

	// the joint reset holds at least the minimum time and as long as the pin stays low
	always_ff @(posedge CLOCK_I)
	begin
		if (RESET_I)
			joint_cnt <= prds_pkg::CNT_LOAD;
		else if (state != prds_pkg::PRDS_RESET || pin_rst)
			joint_cnt <= prds_pkg::CNT_LOAD;
		else if (joint_cnt != prds_pkg::CNT_ONE)
			joint_cnt <= joint_cnt - prds_pkg::CNT_ONE;
	end

	// ****************************************
	// internal-only reset (max reset, state control)
	// ****************************************
	always_ff @(posedge CLOCK_I)
	begin
		if (RESET_I)
			int_cnt <= prds_pkg::CNT_ZERO;
		else if (max_hit || sc_accept)
			int_cnt <= prds_pkg::CNT_LOAD;
		else if (int_cnt != prds_pkg::CNT_ZERO)
			int_cnt <= int_cnt - prds_pkg::CNT_ONE;
	end

	// the max conflict flag pulses for one cycle, the refusal flag stays up while the request is held; the external reset is never driven from here
	always_ff @(posedge CLOCK_I)
	begin
		if (RESET_I)
		begin
			STATE_CTRL_REFUSED_O <= 1'b0;
			MAX_RESET_CONFLICT_O <= 1'b0;
		end
		else
		begin
			STATE_CTRL_REFUSED_O <= STATE_CTRL_DISABLE_I && configured;
			MAX_RESET_CONFLICT_O <= max_hit && configured;
		end
	end

	// ****************************************
	// enable bits
	// ****************************************
	always_ff @(posedge CLOCK_I)
	begin
		if (RESET_I || in_reset || state == prds_pkg::PRDS_CLEAR)
		begin
			slave_control_reg <= prds_pkg::BASE_EN_RST;
			bus_master_enable <= prds_pkg::BME_RST;
			memory_space_enable <= prds_pkg::MSE_RST;
		end
		else if (wr_any && wr_open)
		begin
			slave_control_reg <= WR_BASE_EN_I;
			bus_master_enable <= WR_BUS_MASTER_ENABLE_I;
			memory_space_enable <= WR_MEMORY_SPACE_ENABLE_I;
		end
	end

	// value the memory-space flop takes at this edge, so the answer output never lags a clear
	always_comb
	begin
		if (in_reset || state == prds_pkg::PRDS_CLEAR)
			next_mse = prds_pkg::MSE_RST;
		else if (wr_any && wr_open)
			next_mse = WR_MEMORY_SPACE_ENABLE_I;
		else
			next_mse = memory_space_enable;
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (RESET_I || in_reset)
			configured <= 1'b0;
		else if (state == prds_pkg::PRDS_RECFG && RECONFIG_DONE_I && !pin_rst)
			configured <= 1'b1;
		else if (state == prds_pkg::PRDS_CLEAR)
			configured <= 1'b0;
	end

	// ****************************************
	// outputs
	// ****************************************
	always_ff @(posedge CLOCK_I)
	begin
		if (RESET_I)
		begin
			PCI_INT_RST_O <= 1'b1;
			DEVICE_RST_O <= 1'b1;
			PCI_OE_N_O <= 1'b1;
			STOP_XFER_O <= 1'b1;
			ACCESS_RESPOND_O <= 1'b0;
			XFER_ALLOW_O <= 1'b0;
			SEQ_BUSY_O <= 1'b1;
		end
		else
		begin
			// the pci reset follows in_reset, the device reset only the reset state, so a max or state-control reset raises the pci reset alone
			// only this device and its pci are reset, no bus-wide reset leaves here
			PCI_INT_RST_O <= in_reset;
			DEVICE_RST_O <= state == prds_pkg::PRDS_RESET;
			PCI_OE_N_O <= in_reset || !configured;
			STOP_XFER_O <= state != prds_pkg::PRDS_IDLE && state != prds_pkg::PRDS_PARK;
			ACCESS_RESPOND_O <= configured && !in_reset && next_mse;
			XFER_ALLOW_O <= configured && !in_reset && state == prds_pkg::PRDS_IDLE;
			SEQ_BUSY_O <= state != prds_pkg::PRDS_IDLE;
		end
	end

	assign SLAVE_BASE_EN_O = slave_control_reg;
	assign BUS_MASTER_ENABLE_O = bus_master_enable;
	assign MEMORY_SPACE_ENABLE_O = memory_space_enable;
endmodule

// ### hw/prds_sync.sv
`timescale 1ns/1ps
module prds_sync
(
	input wire logic clock_i,
	input wire logic reset_i,
	prds_sync_if.sync port
);
	logic [prds_pkg::SYNC_W-1:0] s1;
	logic [prds_pkg::SYNC_W-1:0] s2;
	logic [prds_pkg::SYNC_W-1:0] s3;
	logic [prds_pkg::SYNC_W-1:0] clean;

	// ****************************************
	// three-stage capture, a high accepted only on agreement
	// ****************************************
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			s1 <= prds_pkg::SYNC_RST;
			s2 <= prds_pkg::SYNC_RST;
			s3 <= prds_pkg::SYNC_RST;
		end
		else
		begin
			s1 <= port.raw;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// a bit rises only when stages two and three agree and drops whenever they disagree, which filters a one-cycle high glitch only
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
			clean <= prds_pkg::SYNC_RST;
		else
			clean <= (clean & ~(s2 ^ s3)) | (s2 & ~(s2 ^ s3));
	end

	assign port.clean = clean;
endmodule

// ### hw/prds_sync_if.sv
`timescale 1ns/1ps
interface prds_sync_if;
	logic [prds_pkg::SYNC_W-1:0] raw;
	logic [prds_pkg::SYNC_W-1:0] clean;
	modport sync (input raw, output clean);
	modport user (output raw, input clean);
endinterface

// ### testbench/prds_pci_model.sv
`timescale 1ns/1ps
// ****************************************
// far pci system: pin reset joins device reset
// ****************************************
module prds_pci_model
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic dev_rst_i,
	input wire logic park_i,
	output logic rst_n_o,
	output logic parked_o
);
	logic [2:0] cnt;
	logic dev_q;
	always_ff @(posedge clk_i)
	begin
		dev_q <= dev_rst_i;
		if (rst_i)
			cnt <= 3'h0;
		else if (dev_rst_i && !dev_q)
			cnt <= 3'h6;
		else if (cnt != 3'h0)
			cnt <= cnt - 3'h1;
	end
	// a pulse only: a pin held low would keep the device in reset for good
	assign rst_n_o = (cnt == 3'h0);
	assign parked_o = park_i;
endmodule

// ### testbench/prds_seq_monitor.sv
`timescale 1ns/1ps
module prds_seq_monitor
(
	input wire logic CLOCK_I,
	input wire logic RESET_I,
	input wire logic LOCAL_WR_I,
	input wire logic HOST_WR_I,
	input wire logic WR_BUS_MASTER_ENABLE_I,
	input wire logic MAX_RESET_REQ_I,
	input wire logic STATE_CTRL_DISABLE_I,
	input wire logic PCI_INT_RST_O,
	input wire logic DEVICE_RST_O,
	input wire logic PCI_OE_N_O,
	input wire logic STOP_XFER_O,
	input wire logic [prds_pkg::BASE_EN_W-1:0] SLAVE_BASE_EN_O,
	input wire logic BUS_MASTER_ENABLE_O,
	input wire logic MEMORY_SPACE_ENABLE_O,
	input wire logic ACCESS_RESPOND_O,
	input wire logic XFER_ALLOW_O,
	input wire logic SEQ_BUSY_O,
	input wire logic STATE_CTRL_REFUSED_O
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (RESET_I);
	property p_oe;
		DEVICE_RST_O || PCI_INT_RST_O |-> PCI_OE_N_O;
	endproperty
	a_oe: assert property (p_oe) else $error("pins driven in reset");
	property p_joint;
		$rose(DEVICE_RST_O) |-> (PCI_INT_RST_O && STOP_XFER_O && DEVICE_RST_O)[*8];
	endproperty
	a_joint: assert property (p_joint) else $error("joint reset broken");
	property p_stop;
		$rose(DEVICE_RST_O) |-> $past(STOP_XFER_O);
	endproperty
	a_stop: assert property (p_stop) else $error("reset before stop");
	property p_clr;
		DEVICE_RST_O |-> SLAVE_BASE_EN_O == 6'h00 && !BUS_MASTER_ENABLE_O
			&& !MEMORY_SPACE_ENABLE_O && SEQ_BUSY_O;
	endproperty
	a_clr: assert property (p_clr) else $error("enables set in reset");
	property p_resp;
		ACCESS_RESPOND_O |-> MEMORY_SPACE_ENABLE_O && !PCI_INT_RST_O && !PCI_OE_N_O;
	endproperty
	a_resp: assert property (p_resp) else $error("answer while unconfigured");
	property p_xfer;
		XFER_ALLOW_O |-> !DEVICE_RST_O && !PCI_INT_RST_O;
	endproperty
	a_xfer: assert property (p_xfer) else $error("traffic during reset");
	property p_wr;
		(LOCAL_WR_I || HOST_WR_I) && !SEQ_BUSY_O && !PCI_INT_RST_O
			|=> BUS_MASTER_ENABLE_O == $past(WR_BUS_MASTER_ENABLE_I);
	endproperty
	a_wr: assert property (p_wr) else $error("write lost");
	property p_max;
		MAX_RESET_REQ_I && !PCI_INT_RST_O && !DEVICE_RST_O
			|-> ##[1:4] (PCI_INT_RST_O && !DEVICE_RST_O);
	endproperty
	a_max: assert property (p_max) else $error("max reset wrong");
	property p_ref;
		STATE_CTRL_REFUSED_O |-> !PCI_INT_RST_O
			&& ($past(STATE_CTRL_DISABLE_I) || STATE_CTRL_DISABLE_I);
	endproperty
	a_ref: assert property (p_ref) else $error("bad refusal");
endmodule

// ### testbench/tb_prds_sequencer.sv
`timescale 1ns/1ps
module tb_prds_sequencer;
	logic CLOCK_I, RESET_I, DISCONNECT_REQ_I, DMA_BUSY_I, MASTER_BUSY_I, LOCAL_WR_I;
	logic HOST_WR_I, WR_BUS_MASTER_ENABLE_I, WR_MEMORY_SPACE_ENABLE_I, RECONFIG_DONE_I;
	logic MAX_RESET_REQ_I, STATE_CTRL_DISABLE_I, park, sticky, PCI_RST_N_I, BUS_PARKED_I;
	logic [5:0] WR_BASE_EN_I, b;
	logic PCI_INT_RST_O, DEVICE_RST_O, PCI_OE_N_O, STOP_XFER_O, BUS_MASTER_ENABLE_O;
	logic MEMORY_SPACE_ENABLE_O, ACCESS_RESPOND_O, XFER_ALLOW_O, SEQ_BUSY_O, refused;
	logic conflict, conflict_seen;
	logic [5:0] SLAVE_BASE_EN_O;
	logic [15:0] q[$];
	int miscompares = 0, tests_run = 0, n;
	wire [15:0] obs = {sticky, PCI_INT_RST_O, DEVICE_RST_O, PCI_OE_N_O, STOP_XFER_O,
		SLAVE_BASE_EN_O, BUS_MASTER_ENABLE_O, MEMORY_SPACE_ENABLE_O, ACCESS_RESPOND_O,
		XFER_ALLOW_O, SEQ_BUSY_O};
	prds_sequencer dut_u (.CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .PCI_RST_N_I(PCI_RST_N_I),
		.BUS_PARKED_I(BUS_PARKED_I), .DISCONNECT_REQ_I(DISCONNECT_REQ_I),
		.DMA_BUSY_I(DMA_BUSY_I), .MASTER_BUSY_I(MASTER_BUSY_I), .LOCAL_WR_I(LOCAL_WR_I),
		.HOST_WR_I(HOST_WR_I), .WR_BASE_EN_I(WR_BASE_EN_I),
		.WR_BUS_MASTER_ENABLE_I(WR_BUS_MASTER_ENABLE_I),
		.WR_MEMORY_SPACE_ENABLE_I(WR_MEMORY_SPACE_ENABLE_I),
		.RECONFIG_DONE_I(RECONFIG_DONE_I), .MAX_RESET_REQ_I(MAX_RESET_REQ_I),
		.STATE_CTRL_DISABLE_I(STATE_CTRL_DISABLE_I), .PCI_INT_RST_O(PCI_INT_RST_O),
		.DEVICE_RST_O(DEVICE_RST_O), .PCI_OE_N_O(PCI_OE_N_O), .STOP_XFER_O(STOP_XFER_O),
		.SLAVE_BASE_EN_O(SLAVE_BASE_EN_O), .BUS_MASTER_ENABLE_O(BUS_MASTER_ENABLE_O),
		.MEMORY_SPACE_ENABLE_O(MEMORY_SPACE_ENABLE_O), .ACCESS_RESPOND_O(ACCESS_RESPOND_O),
		.XFER_ALLOW_O(XFER_ALLOW_O), .SEQ_BUSY_O(SEQ_BUSY_O),
		.STATE_CTRL_REFUSED_O(refused), .MAX_RESET_CONFLICT_O(conflict));
	prds_pci_model far_u (.clk_i(CLOCK_I), .rst_i(RESET_I), .dev_rst_i(DEVICE_RST_O),
		.park_i(park), .rst_n_o(PCI_RST_N_I), .parked_o(BUS_PARKED_I));
	// ****************************************
	// clock, checking and closing
	// ****************************************
	initial
	begin
		CLOCK_I = 0;
		forever #4 CLOCK_I = ~CLOCK_I;
	end
	// one-cycle flags are caught here so the checks need not hit the exact cycle
	always @(posedge CLOCK_I)
	begin
		sticky <= RESET_I ? 1'b0 : sticky | (refused === 1'b1);
		conflict_seen <= RESET_I ? 1'b0 : conflict_seen | (conflict !== 1'b0);
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e)
		begin
			miscompares++;
			$display("wrong value at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	always @(negedge CLOCK_I)
		if (q.size() > 0)
			chk(obs, q.pop_front());
	task automatic cyc(input int k);
		repeat (k) @(posedge CLOCK_I);
		#1;
	endtask
	task automatic end_sim;
		$display("comparisons %0d, miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wr(input logic host);
		b = 6'($urandom);
		{LOCAL_WR_I, HOST_WR_I, WR_BASE_EN_I} = {~host, host, b};
		{WR_BUS_MASTER_ENABLE_I, WR_MEMORY_SPACE_ENABLE_I} = 2'h3;
		cyc(1);
		{LOCAL_WR_I, HOST_WR_I} = 2'h0;
	endtask
	initial
	begin
		#160000;
		miscompares++;
		end_sim();
	end
	// ****************************************
	// scenarios
	// ****************************************
	initial
	begin
		{RESET_I, DISCONNECT_REQ_I, DMA_BUSY_I, MASTER_BUSY_I, LOCAL_WR_I, HOST_WR_I} = 6'h20;
		{WR_BUS_MASTER_ENABLE_I, WR_MEMORY_SPACE_ENABLE_I, RECONFIG_DONE_I} = 3'h0;
		{MAX_RESET_REQ_I, STATE_CTRL_DISABLE_I, park, WR_BASE_EN_I} = 9'h0;
		void'($urandom(32'h69ff));
		cyc(3);
		q.push_back({5'b01111, 6'h00, 5'b00001});
		cyc(1);
		RESET_I = 0;
		cyc(1);
		q.push_back({5'b00011, 6'h00, 5'b00001});
		wr(0);
		RECONFIG_DONE_I = 1;
		cyc(1);
		RECONFIG_DONE_I = 0;
		cyc(3);
		q.push_back({5'b00000, b, 5'b11110});
		wr(1);
		cyc(2);
		q.push_back({5'b00000, b, 5'b11110});
		STATE_CTRL_DISABLE_I = 1;
		cyc(1);
		STATE_CTRL_DISABLE_I = 0;
		cyc(3);
		q.push_back({5'b10000, b, 5'b11110});
		// park first and let the pin filter settle, else the sequencer sees an unparked bus
		park = 1;
		cyc(4);
		{DMA_BUSY_I, MASTER_BUSY_I, DISCONNECT_REQ_I} = 3'h7;
		cyc(1);
		DISCONNECT_REQ_I = 0;
		cyc(10);
		chk({14'h0, STOP_XFER_O, DEVICE_RST_O}, 16'h0);
		park = 0;
		cyc(10);
		chk({14'h0, STOP_XFER_O, DEVICE_RST_O}, 16'h2);
		{DMA_BUSY_I, MASTER_BUSY_I} = 2'h0;
		for (n = 0; n < 20 && DEVICE_RST_O !== 1'b1; n++)
			cyc(1);
		cyc(1);
		q.push_back({5'b11111, 6'h00, 5'b00001});
		for (n = 0; n < 200 && DEVICE_RST_O !== 1'b0; n++)
			cyc(1);
		cyc(1);
		q.push_back({5'b10011, 6'h00, 5'b00001});
		MAX_RESET_REQ_I = 1;
		cyc(1);
		MAX_RESET_REQ_I = 0;
		cyc(1);
		q.push_back({5'b11011, 6'h00, 5'b00001});
		cyc(19);
		chk({15'h0, conflict_seen}, 16'h0);
		end_sim();
	end
endmodule
bind prds_sequencer prds_seq_monitor mon_u (.CLOCK_I(CLOCK_I), .RESET_I(RESET_I),
	.LOCAL_WR_I(LOCAL_WR_I), .HOST_WR_I(HOST_WR_I),
	.WR_BUS_MASTER_ENABLE_I(WR_BUS_MASTER_ENABLE_I), .MAX_RESET_REQ_I(MAX_RESET_REQ_I),
	.STATE_CTRL_DISABLE_I(STATE_CTRL_DISABLE_I), .PCI_INT_RST_O(PCI_INT_RST_O),
	.DEVICE_RST_O(DEVICE_RST_O), .PCI_OE_N_O(PCI_OE_N_O), .STOP_XFER_O(STOP_XFER_O),
	.SLAVE_BASE_EN_O(SLAVE_BASE_EN_O), .BUS_MASTER_ENABLE_O(BUS_MASTER_ENABLE_O),
	.MEMORY_SPACE_ENABLE_O(MEMORY_SPACE_ENABLE_O), .ACCESS_RESPOND_O(ACCESS_RESPOND_O),
	.XFER_ALLOW_O(XFER_ALLOW_O), .SEQ_BUSY_O(SEQ_BUSY_O),
	.STATE_CTRL_REFUSED_O(STATE_CTRL_REFUSED_O));
